/* File: core/hbp_host_port.sv */
// Host bus pin interface: parallel and serial host access to the device
`timescale 1ns/10ps
`default_nettype none
module hbp_host_port (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ext_reset_n,      // External reset pin
  input  wire logic [1:0]        strap_mode,       // Mode strap pins
  input  wire logic              strap_width16,    // Data width strap
  input  wire hbp_pkg::hbp_cfg_t cfg,              // Polarity and mode settings
  input  wire logic              rd,               // Read strobe
  input  wire logic              rd_wr,            // Direction control
  input  wire logic              wr,               // Write strobe
  input  wire logic              data_phase_strobe,
  input  wire logic              cs,               // Device select
  input  wire logic [4:0]        addr_in,          // Non-multiplexed address
  input  wire logic [15:0]       data_in,          // Data or address/data lines
  output logic [15:0]            data_out,
  output logic [15:0]            data_oe,
  input  wire logic              high_byte_latch,
  input  wire logic              low_byte_latch,
  input  wire logic              serial_select_n,
  input  wire logic              serial_clk,
  input  wire logic [3:0]        quad_io_in,
  output logic [3:0]             quad_io_out,
  output logic [3:0]             quad_io_oe,
  output hbp_pkg::hbp_req_t      req,              // Request to internal memory
  input  wire logic [15:0]       rd_data,          // Read data, one cycle after req
  output hbp_pkg::hbp_mode_t     mode,             // Latched mode
  output logic                   width16           // Latched data width
);

  // Strobe active test for a given polarity setting
  function automatic logic act(input logic pin, input logic pol);
    act = ~(pin ^ pol);
  endfunction

  // Strap latch state
  hbp_pkg::hbp_mode_t mode_q, mode_d;   // Latched mode
  logic width16_q, width16_d;           // Latched width
  logic strap_done_q, strap_done_d;     // First capture after power-on done
  logic ext_prev_q, ext_prev_d;         // Previous external reset level

  // Strap capture after power-on and on external reset release
  always_comb
  begin
    mode_d       = mode_q;
    width16_d    = width16_q;
    strap_done_d = 1'b1;
    ext_prev_d   = ext_reset_n;
    if (!strap_done_q || (ext_reset_n && !ext_prev_q))
    begin
      mode_d    = hbp_pkg::hbp_mode_t'(strap_mode);
      width16_d = strap_width16;
    end
  end

  // Strap registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_q       <= hbp_pkg::HBP_NONMUX;
      width16_q    <= 1'b0;
      strap_done_q <= 1'b0;
      ext_prev_q   <= 1'b0;
    end
    else
    begin
      mode_q       <= mode_d;
      width16_q    <= width16_d;
      strap_done_q <= strap_done_d;
      ext_prev_q   <= ext_prev_d;
    end
  end

  // Decoded parallel strobes
  logic        par_mode;     // A parallel mode is active
  logic        sel;          // Device selected
  logic        dir_rd;       // Direction says read
  logic        en_act;       // Data-phase strobe active
  logic        rd_phase;     // Selected read data phase
  logic        wr_phase;     // Selected write data phase
  logic        hi_act;       // High-byte latch active
  logic        lo_act;       // Low-byte latch active
  logic        upper_used;   // Upper lines carry information
  logic [15:0] din;          // Masked data lines

  // Strobe decoding with polarity settings
  always_comb
  begin
    par_mode   = (mode_q != hbp_pkg::HBP_SERIAL);
    sel        = act(cs, cfg.cs_pol);
    dir_rd     = rd_wr ^ cfg.rd_pol;
    en_act     = act(data_phase_strobe, cfg.wr_pol);
    if (cfg.dir_strobe)
    begin
      rd_phase = par_mode && sel && en_act && dir_rd;
      wr_phase = par_mode && sel && en_act && !dir_rd;
    end
    else
    begin
      rd_phase = par_mode && sel && act(rd, cfg.rd_pol);
      wr_phase = par_mode && sel && act(wr, cfg.wr_pol);
    end
    hi_act     = act(high_byte_latch, cfg.ale_pol);
    lo_act     = act(low_byte_latch, cfg.ale_pol);
    upper_used = width16_q || (mode_q == hbp_pkg::HBP_MUX_SINGLE);
    din        = upper_used ? data_in : {8'h00, data_in[7:0]};
  end

  // Parallel state
  logic        rd_prev_q, rd_prev_d;   // Read phase last cycle
  logic        wr_prev_q, wr_prev_d;   // Write phase last cycle
  logic        hi_prev_q, hi_prev_d;   // High latch last cycle
  logic        lo_prev_q, lo_prev_d;   // Low latch last cycle
  logic [15:0] din_q, din_d;           // Lines sampled last cycle
  logic [4:0]  ain_q, ain_d;           // Address pins sampled last cycle
  logic [15:0] maddr_q, maddr_d;       // Latched multiplexed address
  logic [15:0] dout_q, dout_d;         // Driven read data
  logic [15:0] doe_q, doe_d;           // Data line enables
  logic [15:0] paddr;                  // Address of current access
  logic        p_req;                  // Parallel request pulse
  logic        p_write;                // Parallel request is a write

  // Parallel address, latches, data drive and requests
  always_comb
  begin
    rd_prev_d = rd_phase;
    wr_prev_d = wr_phase;
    hi_prev_d = hi_act;
    lo_prev_d = lo_act;
    din_d     = din;
    ain_d     = addr_in;
    maddr_d   = maddr_q;
    // Trailing edge of a latch stores last sampled lines
    if (par_mode && hi_prev_q && !hi_act && mode_q == hbp_pkg::HBP_MUX_DUAL)
    begin
      maddr_d[15:8] = din_q[7:0];
    end
    if (par_mode && lo_prev_q && !lo_act)
    begin
      if (mode_q == hbp_pkg::HBP_MUX_SINGLE)
      begin
        maddr_d = din_q;
      end
      else
      begin
        maddr_d[7:0] = din_q[7:0];
      end
    end
    if (mode_q == hbp_pkg::HBP_NONMUX)
    begin
      paddr = {11'h000, addr_in[4:1], addr_in[0] & !width16_q};
      // Writes end after the strobe; use the last active address
      if (!rd_phase)
      begin
        paddr = {11'h000, ain_q[4:1], ain_q[0] & !width16_q};
      end
    end
    else
    begin
      paddr = maddr_q;
    end
    // Read at phase start, write at phase end
    p_req   = (rd_phase && !rd_prev_q) || (wr_prev_q && !wr_phase);
    p_write = !rd_phase;
    dout_d  = rd_phase ? rd_data : hbp_pkg::HBP_WORD_RST;
    doe_d   = rd_phase ? (width16_q ? 16'hFFFF : 16'h00FF)
                       : hbp_pkg::HBP_WORD_RST;
  end

  // Parallel registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      hi_prev_q <= 1'b0;
      lo_prev_q <= 1'b0;
      din_q     <= hbp_pkg::HBP_WORD_RST;
      ain_q     <= 5'h00;
      maddr_q   <= hbp_pkg::HBP_WORD_RST;
      dout_q    <= hbp_pkg::HBP_WORD_RST;
      doe_q     <= hbp_pkg::HBP_WORD_RST;
    end
    else
    begin
      rd_prev_q <= rd_prev_d;
      wr_prev_q <= wr_prev_d;
      hi_prev_q <= hi_prev_d;
      lo_prev_q <= lo_prev_d;
      din_q     <= din_d;
      ain_q     <= ain_d;
      maddr_q   <= maddr_d;
      dout_q    <= dout_d;
      doe_q     <= doe_d;
    end
  end

  // Serial frame phases, shared through the package
  typedef hbp_pkg::hbp_sstate_t hbp_sstate_t;

  hbp_sstate_t st_q, st_d;              // Frame phase
  logic        sclk_q, sclk_d;          // Serial clock last cycle
  logic [4:0]  cnt_q, cnt_d;            // Bits taken in this field
  logic [15:0] sh_q, sh_d;              // Receive shift register
  logic [15:0] saddr_q, saddr_d;        // Serial access address
  logic [7:0]  tx_q, tx_d;              // Transmit shift register
  logic        load_q, load_d;          // Load read data next cycle
  logic        tx_ld_q, tx_ld_d;        // Memory answer stands this cycle
  logic        rdcmd_q, rdcmd_d;        // Frame carries a read command
  logic [3:0]  sio_q, sio_d;            // Driven serial lines
  logic [3:0]  soe_q, soe_d;            // Serial line enables
  logic        s_req;                   // Serial request pulse
  logic        s_write;                 // Serial request is a write
  logic [15:0] sh_in;                   // Shift register with new bits
  logic [4:0]  step;                    // Bits per clock edge
  logic [4:0]  cnt_n;                   // Count after this edge
  logic        s_act;                   // Serial frame in progress
  logic        rise;                    // Serial clock rising edge
  logic        fall;                    // Serial clock falling edge

  // Serial frame decoding, transmit and requests
  always_comb
  begin
    st_d    = st_q;
    sclk_d  = serial_clk;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    saddr_d = saddr_q;
    tx_d    = tx_q;
    load_d  = 1'b0;
    tx_ld_d = load_q;
    rdcmd_d = rdcmd_q;
    sio_d   = sio_q;
    soe_d   = soe_q;
    s_req   = 1'b0;
    s_write = 1'b0;
    s_act   = (mode_q == hbp_pkg::HBP_SERIAL) && !serial_select_n;
    rise    = serial_clk && !sclk_q;
    fall    = !serial_clk && sclk_q;
    step    = cfg.quad_en ? hbp_pkg::HBP_STEP_QUAD : hbp_pkg::HBP_STEP_SINGLE;
    cnt_n   = cnt_q + step;
    sh_in   = cfg.quad_en ? {sh_q[11:0], quad_io_in}
                          : {sh_q[14:0], quad_io_in[0]};
    // Memory answers the cycle after the request pulse
    if (tx_ld_q)
    begin
      tx_d = rd_data[7:0];
    end
    if (!s_act)
    begin
      st_d  = hbp_pkg::HBP_S_CMD;
      cnt_d = 5'h00;
      soe_d = hbp_pkg::HBP_NIB_RST;
    end
    else if (rise)
    begin
      sh_d  = sh_in;
      cnt_d = cnt_n;
      case (st_q)
        hbp_pkg::HBP_S_CMD:
        begin
          if (cnt_n == hbp_pkg::HBP_CMD_BITS)
          begin
            cnt_d = 5'h00;
            // Command bits are shifted out by the address, keep its kind
            rdcmd_d = (sh_in[7:0] == hbp_pkg::HBP_CMD_READ);
            if (sh_in[7:0] == hbp_pkg::HBP_CMD_READ ||
                sh_in[7:0] == hbp_pkg::HBP_CMD_WRITE)
            begin
              st_d = hbp_pkg::HBP_S_ADDR;
            end
            else
            begin
              st_d = hbp_pkg::HBP_S_IGNORE;
            end
          end
        end
        hbp_pkg::HBP_S_ADDR:
        begin
          if (cnt_n == hbp_pkg::HBP_ADDR_BITS)
          begin
            cnt_d   = 5'h00;
            saddr_d = sh_in;
            if (rdcmd_q)
            begin
              st_d   = hbp_pkg::HBP_S_RDATA;
              s_req  = 1'b1;
              load_d = 1'b1;
            end
            else
            begin
              st_d = hbp_pkg::HBP_S_WDATA;
            end
          end
        end
        hbp_pkg::HBP_S_WDATA:
        begin
          if (cnt_n == hbp_pkg::HBP_DATA_BITS)
          begin
            cnt_d   = 5'h00;
            s_req   = 1'b1;
            s_write = 1'b1;
            saddr_d = saddr_q + 16'h0001;
          end
        end
        hbp_pkg::HBP_S_RDATA:
        begin
          if (cnt_n == hbp_pkg::HBP_DATA_BITS)
          begin
            cnt_d   = 5'h00;
            saddr_d = saddr_q + 16'h0001;
            s_req   = 1'b1;
            load_d  = 1'b1;
          end
        end
        default:
        begin
          cnt_d = 5'h00;
        end
      endcase
    end
    else if (fall && st_q == hbp_pkg::HBP_S_RDATA)
    begin
      if (cfg.quad_en)
      begin
        sio_d = tx_q[7:4];
        soe_d = 4'hF;
        tx_d  = {tx_q[3:0], 4'h0};
      end
      else
      begin
        sio_d = {2'b00, tx_q[7], 1'b0};
        soe_d = 4'h2;
        tx_d  = {tx_q[6:0], 1'b0};
      end
    end
  end

  // Serial registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q    <= hbp_pkg::HBP_S_CMD;
      sclk_q  <= 1'b0;
      cnt_q   <= 5'h00;
      sh_q    <= hbp_pkg::HBP_WORD_RST;
      saddr_q <= hbp_pkg::HBP_WORD_RST;
      tx_q    <= hbp_pkg::HBP_BYTE_RST;
      load_q  <= 1'b0;
      tx_ld_q <= 1'b0;
      rdcmd_q <= 1'b0;
      sio_q   <= hbp_pkg::HBP_NIB_RST;
      soe_q   <= hbp_pkg::HBP_NIB_RST;
    end
    else
    begin
      st_q    <= st_d;
      sclk_q  <= sclk_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      saddr_q <= saddr_d;
      tx_q    <= tx_d;
      load_q  <= load_d;
      tx_ld_q <= tx_ld_d;
      rdcmd_q <= rdcmd_d;
      sio_q   <= sio_d;
      soe_q   <= soe_d;
    end
  end

  // Request state
  hbp_pkg::hbp_req_t req_q, req_d;

  // Merge parallel and serial requests; modes never overlap
  always_comb
  begin
    req_d       = '0;
    if (s_req)
    begin
      req_d.valid    = 1'b1;
      req_d.write    = s_write;
      req_d.byte_acc = 1'b1;
      req_d.addr     = s_write ? saddr_q : (st_q == hbp_pkg::HBP_S_ADDR ? sh_in
                                                                      : saddr_q + 16'h0001);
      req_d.wdata    = {8'h00, sh_in[7:0]};
    end
    else if (p_req)
    begin
      req_d.valid    = 1'b1;
      req_d.write    = p_write;
      req_d.byte_acc = !width16_q;
      req_d.addr     = paddr;
      req_d.wdata    = din_q;
    end
  end

  // Request register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_q <= '0;
    end
    else
    begin
      req_q <= req_d;
    end
  end

  // Outputs straight from flip-flops
  assign data_out    = dout_q;
  assign data_oe     = doe_q;
  assign quad_io_out = sio_q;
  assign quad_io_oe  = soe_q;
  assign req         = req_q;
  assign mode        = mode_q;
  assign width16     = width16_q;

endmodule
`default_nettype wire

/* File: core/hbp_pkg.sv */
// Package of constants and types for the host bus pin interface
package hbp_pkg;

  // Host port operating modes, taken from the mode straps
  typedef enum logic [1:0] {
    HBP_NONMUX,
    HBP_MUX_SINGLE,
    HBP_MUX_DUAL,
    HBP_SERIAL
  } hbp_mode_t;

  // Configuration bits; a set polarity bit means active high
  typedef struct packed {
    logic rd_pol;       // Read strobe and direction polarity
    logic wr_pol;       // Write strobe and data-phase strobe polarity
    logic cs_pol;       // Device-select polarity
    logic ale_pol;      // Address-latch polarity
    logic dir_strobe;   // Use direction plus data-phase strobe
    logic quad_en;      // Serial transfers on all four lines
  } hbp_cfg_t;

  // Access request toward the internal memory
  typedef struct packed {
    logic        valid;     // One-cycle request pulse
    logic        write;     // Write when set, read otherwise
    logic        byte_acc;  // Byte-wide access
    logic [15:0] addr;      // Byte address
    logic [15:0] wdata;     // Write data
  } hbp_req_t;

  // Serial frame phases
  typedef enum logic [2:0] {
    HBP_S_CMD,
    HBP_S_ADDR,
    HBP_S_WDATA,
    HBP_S_RDATA,
    HBP_S_IGNORE
  } hbp_sstate_t;

  // Serial frame command codes
  localparam logic [7:0]  HBP_CMD_READ   = 8'h03;
  localparam logic [7:0]  HBP_CMD_WRITE  = 8'h02;
  // Reset values
  localparam logic [15:0] HBP_WORD_RST   = 16'h0000;
  localparam logic [7:0]  HBP_BYTE_RST   = 8'h00;
  localparam logic [3:0]  HBP_NIB_RST    = 4'h0;
  // Serial frame field lengths in bits
  localparam logic [4:0]  HBP_CMD_BITS   = 5'h08;
  localparam logic [4:0]  HBP_ADDR_BITS  = 5'h10;
  localparam logic [4:0]  HBP_DATA_BITS  = 5'h08;
  // Bits moved per serial clock edge
  localparam logic [4:0]  HBP_STEP_QUAD  = 5'h04;
  localparam logic [4:0]  HBP_STEP_SINGLE = 5'h01;

endpackage

/* File: dv/hbp_host_model.sv */
// Host microcontroller model on the parallel and serial host pins
`timescale 1ns/10ps
`default_nettype none
module hbp_host_model (
  input  wire logic              clk,
  input  wire hbp_pkg::hbp_cfg_t cfg,
  input  wire logic [15:0]       data_out,
  input  wire logic [15:0]       data_oe,
  input  wire logic [3:0]        quad_io_out,
  input  wire logic [3:0]        quad_io_oe,
  output logic                   rd,
  output logic                   rd_wr,
  output logic                   wr,
  output logic                   data_phase_strobe,
  output logic                   cs,
  output logic [4:0]             addr_in,
  output logic [15:0]            data_in,
  output logic                   high_byte_latch,
  output logic                   low_byte_latch,
  output logic                   serial_select_n,
  output logic                   serial_clk,
  output logic [3:0]             quad_io_in
);
  logic [15:0] hd = 16'h0000; // Last value put on the data lines
  logic        hoe;           // Host drives the data lines
  logic [3:0]  hq;            // Host serial line values
  logic [3:0]  hqoe;          // Host drives serial lines
  // Wire level from both parties; released data lines show the inverse, released serial lines read 1
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      data_in[i] = data_oe[i] ? data_out[i] : (hoe ? hd[i] : ~hd[i]);
    for (int i = 0; i < 4; i++)
      quad_io_in[i] = quad_io_oe[i] ? quad_io_out[i] : (hqoe[i] ? hq[i] : 1'b1);
  end
  // Park all strobes inactive and release the lines
  task automatic park();
    rd = ~cfg.rd_pol;
    wr = ~cfg.wr_pol;
    data_phase_strobe = ~cfg.wr_pol;
    cs = ~cfg.cs_pol;
    high_byte_latch = ~cfg.ale_pol;
    low_byte_latch = ~cfg.ale_pol;
    serial_select_n = 1'b1;
    serial_clk = 1'b0;
    rd_wr = 1'b0;
    addr_in = 5'h00;
    hoe = 1'b0;
    hqoe = 4'h0;
  endtask
  // One parallel access, strobe held four cycles
  task automatic par(input logic wrt, input logic [4:0] a, input logic [15:0] d,
                     input logic on, output logic [15:0] q);
    addr_in = a;
    hd = d;
    hoe = wrt;
    rd_wr = ~wrt ^ cfg.rd_pol;
    cs = on ~^ cfg.cs_pol;
    if (cfg.dir_strobe)
      data_phase_strobe = cfg.wr_pol;
    else if (wrt)
      wr = cfg.wr_pol;
    else
      rd = cfg.rd_pol;
    repeat (4) @(negedge clk);
    q = data_in;
    park();
    repeat (3) @(negedge clk);
  endtask
  // Address on the lines, then one latch pulse
  task automatic latch(input logic hi, input logic [15:0] v);
    hd = v;
    hoe = 1'b1;
    @(negedge clk);
    if (hi)
      high_byte_latch = cfg.ale_pol;
    else
      low_byte_latch = cfg.ale_pol;
    repeat (2) @(negedge clk);
    park();
    repeat (3) @(negedge clk);
  endtask
  // Serial select line
  task automatic ssel(input logic n);
    serial_select_n = n;
    @(negedge clk);
  endtask
  // Shift n bits msb first; line 1 sampled at each rising clock
  task automatic spi(input logic [31:0] v, input int n, output logic [7:0] rx);
    int k;
    k = n;
    while (k > 0)
    begin
      if (cfg.quad_en)
      begin
        hq = v[k-1 -: 4];
        hqoe = 4'hF;
        k = k - 4;
      end
      else
      begin
        hq = {3'h7, v[k-1]};
        hqoe = 4'h1;
        k = k - 1;
      end
      repeat (4) @(negedge clk);
      serial_clk = 1'b1;
      rx = {rx[6:0], quad_io_in[1]};
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
    end
    hqoe = 4'h0;
  endtask
endmodule
`default_nettype wire

/* File: dv/hbp_host_port_asserts.sv */
// Assertion checker for the host bus pin interface
`timescale 1ns/10ps
`default_nettype none
module hbp_chk (
  input wire logic               clk,
  input wire logic               resetn,
  input wire hbp_pkg::hbp_cfg_t  cfg,
  input wire logic               rd,
  input wire logic               rd_wr,
  input wire logic               wr,
  input wire logic               data_phase_strobe,
  input wire logic               cs,
  input wire logic [15:0]        data_out,
  input wire logic [15:0]        data_oe,
  input wire logic               serial_select_n,
  input wire logic [3:0]         quad_io_oe,
  input wire hbp_pkg::hbp_req_t  req,
  input wire logic [15:0]        rd_data,
  input wire hbp_pkg::hbp_mode_t mode,
  input wire logic               width16
);
  logic par;   // Parallel mode latched
  logic sel;   // Device selected in parallel mode
  logic rd_ph; // Selected read phase
  logic wr_ph; // Selected write phase
  logic rd_q;  // Read phase a cycle ago
  logic wr_q;  // Write phase a cycle ago
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Decode host strobes under the set polarities
  always_comb
  begin
    par = mode != hbp_pkg::HBP_SERIAL;
    sel = par && (cs == cfg.cs_pol);
    rd_ph = sel && (cfg.dir_strobe ? (data_phase_strobe == cfg.wr_pol) && (rd_wr ^ cfg.rd_pol)
                                   : (rd == cfg.rd_pol));
    wr_ph = sel && (cfg.dir_strobe ? (data_phase_strobe == cfg.wr_pol) && !(rd_wr ^ cfg.rd_pol)
                                   : (wr == cfg.wr_pol));
  end
  // Phase history for start and end detection
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_ph;
      wr_q <= wr_ph;
    end
  end
  a_rd_request: assert property (rd_ph && !rd_q |=> req.valid && !req.write)
    else $error("read phase start without read request");
  a_oe_follow: assert property (1'b1 |=> (data_oe[0] == $past(rd_ph)))
    else $error("data drive not tracking the read phase");
  a_dout_data: assert property (rd_ph |=> data_out[7:0] == $past(rd_data[7:0]))
    else $error("read data not passed to the lines");
  a_oe_width: assert property (data_oe != 16'h0 |->
    data_oe == (width16 ? 16'hFFFF : 16'h00FF)) else $error("wrong lines driven");
  a_wr_request: assert property (wr_q && !wr_ph |=> req.valid && req.write)
    else $error("write phase end without write request");
  a_par_byte: assert property (req.valid && par |-> req.byte_acc == !width16)
    else $error("access size not matching width");
  a_addr_even: assert property (req.valid && width16 && mode == hbp_pkg::HBP_NONMUX |->
    req.addr[0] == 1'b0 && req.addr[15:5] == 11'h0) else $error("bad direct address");
  a_ser_float: assert property (serial_select_n [*2] |-> quad_io_oe == 4'h0)
    else $error("serial lines driven while deselected");
  a_ser_lines: assert property (quad_io_oe != 4'h0 |->
    quad_io_oe == (cfg.quad_en ? 4'hF : 4'h2)) else $error("wrong serial lines driven");
  a_unsel_quiet: assert property ((par && !sel) [*3] |-> data_oe == 16'h0 && !req.valid)
    else $error("activity while not selected");
endmodule
bind hbp_host_port hbp_chk hbp_chk_i (
  .clk, .resetn, .cfg, .rd, .rd_wr, .wr, .data_phase_strobe, .cs, .data_out, .data_oe,
  .serial_select_n, .quad_io_oe, .req, .rd_data, .mode, .width16
);
`default_nettype wire

/* File: dv/hbp_host_port_bench.sv */
// Self-checking testbench for the host bus pin interface
`timescale 1ns/10ps
`default_nettype none
module hbp_host_port_bench;
  logic clk, resetn, ext_reset_n, strap_width16, rd, rd_wr, wr, data_phase_strobe, cs;
  logic high_byte_latch, low_byte_latch, serial_select_n, serial_clk, width16;
  logic [1:0]         strap_mode;
  logic [4:0]         addr_in;
  logic [15:0]        data_in, data_out, data_oe, rd_data, q;
  logic [3:0]         quad_io_in, quad_io_out, quad_io_oe;
  logic [7:0]         rx;
  hbp_pkg::hbp_cfg_t  cfg;
  hbp_pkg::hbp_req_t  req, req_seen;
  hbp_pkg::hbp_mode_t mode;
  int bad_count = 0, samples_checked = 0, req_cnt = 0, exp_cnt = 0;
  hbp_host_port hbp_host_port_i (.clk, .resetn, .ext_reset_n, .strap_mode, .strap_width16,
    .cfg, .rd, .rd_wr, .wr, .data_phase_strobe, .cs, .addr_in, .data_in, .data_out, .data_oe,
    .high_byte_latch, .low_byte_latch, .serial_select_n, .serial_clk, .quad_io_in,
    .quad_io_out, .quad_io_oe, .req, .rd_data, .mode, .width16);
  hbp_host_model hbp_host_model_i (.clk, .cfg, .data_out, .data_oe, .quad_io_out, .quad_io_oe,
    .rd, .rd_wr, .wr, .data_phase_strobe, .cs, .addr_in, .data_in, .high_byte_latch,
    .low_byte_latch, .serial_select_n, .serial_clk, .quad_io_in);
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Record each request pulse
  always @(negedge clk)
    if (req.valid === 1'b1)
    begin
      req_seen <= req;
      req_cnt <= req_cnt + 1;
    end
  // Compare and count
  task automatic check(input logic [49:0] seen, input logic [49:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One new request with these fields
  task automatic chk_req(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
    exp_cnt++;
    check(50'(req_cnt), 50'(exp_cnt));
    check(50'({req_seen.write, req_seen.byte_acc, req_seen.addr,
      w ? (b ? {8'h0, req_seen.wdata[7:0]} : req_seen.wdata) : 16'h0}), 50'({w, b, a, d}));
  endtask
  // Relatch straps through the external reset pin
  task automatic straps(input logic [1:0] m, input logic w);
    strap_mode = m;
    strap_width16 = w;
    ext_reset_n = 1'b0;
    repeat (2) @(negedge clk);
    ext_reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check(50'({mode, width16}), 50'({m, w}));
  endtask
  // New settings, strobes re-parked to match
  task automatic setcfg(input hbp_pkg::hbp_cfg_t c);
    cfg = c;
    hbp_host_model_i.park();
    @(negedge clk);
  endtask
  // Direct 16-bit, 8-bit and inverted-polarity accesses
  task automatic t_direct();
    check(50'({data_oe, quad_io_oe, mode, width16}), 50'h1);
    check(req, 50'h0);
    hbp_host_model_i.par(1'b0, 5'h1F, 16'h0, 1'b1, q);
    chk_req(1'b0, 1'b0, 16'h001E, 16'h0);
    check(50'(q), 50'(rd_data));
    hbp_host_model_i.par(1'b1, 5'h0B, 16'hBEEF, 1'b1, q);
    chk_req(1'b1, 1'b0, 16'h000A, 16'hBEEF);
    hbp_host_model_i.par(1'b0, 5'h03, 16'h0, 1'b0, q);
    check(50'(req_cnt), 50'(exp_cnt));
    straps(2'h0, 1'b0);
    hbp_host_model_i.par(1'b0, 5'h1F, 16'h0, 1'b1, q);
    chk_req(1'b0, 1'b1, 16'h001F, 16'h0);
    check(50'(q), 50'({8'hFF, rd_data[7:0]}));
    setcfg(6'b111010);
    hbp_host_model_i.par(1'b0, 5'h04, 16'h0, 1'b1, q);
    chk_req(1'b0, 1'b1, 16'h0004, 16'h0);
    hbp_host_model_i.par(1'b1, 5'h09, 16'h7711, 1'b1, q);
    chk_req(1'b1, 1'b1, 16'h0009, 16'h0011);
    setcfg(6'h00);
  endtask
  // Multiplexed single and dual phase addressing
  task automatic t_mux();
    straps(2'h1, 1'b1);
    for (int p = 0; p < 2; p++)
    begin
      setcfg({3'h0, p[0], 2'h0});
      hbp_host_model_i.latch(1'b0, {15'h091A, p[0]});
      hbp_host_model_i.par(1'b0, 5'h00, 16'h0, 1'b1, q);
      chk_req(1'b0, 1'b0, {15'h091A, p[0]}, 16'h0);
    end
    straps(2'h2, 1'b0);
    hbp_host_model_i.latch(1'b1, 16'hAA56);
    hbp_host_model_i.latch(1'b0, 16'hBB78);
    hbp_host_model_i.par(1'b0, 5'h00, 16'h0, 1'b1, q);
    chk_req(1'b0, 1'b1, 16'h5678, 16'h0);
    setcfg(6'h00);
  endtask
  // Serial writes in both widths, then a single-line read
  task automatic t_serial();
    straps(2'h3, 1'b0);
    for (int m = 0; m < 2; m++)
    begin
      setcfg({5'h0, m[0]});
      hbp_host_model_i.ssel(1'b0);
      hbp_host_model_i.spi({8'h02, 8'h01, 7'h11, m[0], 8'h5A}, 32, rx);
      chk_req(1'b1, 1'b1, {8'h01, 7'h11, m[0]}, 16'h005A);
      hbp_host_model_i.ssel(1'b1);
    end
    setcfg(6'h00);
    hbp_host_model_i.ssel(1'b0);
    hbp_host_model_i.spi({8'h03, 16'h0040, 8'h00}, 32, rx);
    check(50'(rx), 50'(rd_data[7:0]));
    check(50'(quad_io_oe), 50'h2);
    exp_cnt++;
    chk_req(1'b0, 1'b1, 16'h0041, 16'h0);
    hbp_host_model_i.ssel(1'b1);
    @(negedge clk);
    check(50'(quad_io_oe), 50'h0);
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cut a hang short
  initial
  begin
    #100000;
    bad_count++;
    close_out();
  end
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    ext_reset_n = 1'b1;
    strap_mode = 2'h0;
    strap_width16 = 1'b1;
    cfg = 6'h00;
    rd_data = 16'hC3A5;
    hbp_host_model_i.park();
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_direct();
    t_mux();
    t_serial();
    close_out();
  end
endmodule
`default_nettype wire
